// ---- rtl/sep_pkg.sv ----
package sep_pkg;

  // array geometry: one location holds two 22-bit protected half words
  localparam int MEM_AW = 10;
  localparam int MEM_DEPTH = 1024;
  localparam int DATA_W = 16;
  localparam int CHK_W = 6;
  localparam int WORD_W = 22;
  localparam int PTR_W = MEM_AW + 1;

  // one mask per check bit, index 0 in the low slot
  localparam logic [5:0][15:0] ECC_MASKS = {16'h993c, 16'h3e8a, 16'hee60, 16'he1d1, 16'h13c7, 16'h443f};
  localparam logic [5:0] ZERO_CHECK = 6'h3f;

  // register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_PTR = 5'h08;
  localparam logic [4:0] OFS_DEBUG_RAW_WORD = 5'h0c;
  localparam logic [4:0] OFS_DCHK = 5'h10;
  localparam logic [4:0] OFS_DCMD = 5'h14;

  // field positions
  localparam int BIT_IRQ_EN = 0;
  localparam int BIT_FLAG = 0;
  localparam int BIT_READY = 1;
  localparam int BIT_RRD = 7;
  localparam int BIT_DW = 1;
  localparam int BIT_DR = 0;

  // reset values
  localparam logic RST_IRQ_EN = 1'b0;
  localparam logic RST_RRD = 1'b0;
  localparam logic [PTR_W-1:0] RST_PTR = 11'h000;
  localparam logic [DATA_W-1:0] RST_DEBUG_RAW_WORD = 16'h0000;
  localparam logic [CHK_W-1:0] RST_DCHK = 6'h00;

  typedef enum logic [2:0] {ST_INIT, ST_IDLE, ST_READ, ST_RMW, ST_REPAIR, ST_DBG_RD} sep_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [MEM_AW-1:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } sep_sys_req_t;

  typedef struct packed {
    logic done;
    logic err;
    logic [31:0] rdata;
  } sep_sys_rsp_t;

  typedef struct packed {
    logic [MEM_AW-1:0] addr;
    logic [1:0] we;
    logic [2*WORD_W-1:0] wdata;
  } sep_mem_req_t;

  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic single;
    logic dbl;
  } sep_dec_t;

endpackage

// ---- rtl/sep_ecc_top.sv ----
// Notes on behaviour
// - 1-4 byte writes, check per half word
// - aligned 2/4 byte write in one cycle
// - other writes read, merge, then write back
// - merge read single error: correct, write, flag
// - merge read double error in a touched half: drop write, report
// - reads checked, clean data in two cycles
// - read single error corrected, repaired unless disabled
// - repair delays next read one cycle
// - read single error always sets flag
// - read double error marked invalid, double half kept
// - interrupt only when flag and enable set
// - double errors in reads and in touched merge halves go out, no interrupt
// - power-up zero fill, ready set afterwards
// - check bits 0-2 from first three masks
// - check bits 3-5 from last three masks
// - debug accesses have lowest priority
// - debug request waits for zero fill end
// - repair disabled: correct data, flag, no write
// - debug command set ignored while one pending
// - debug write stores raw half word, clears bit
// - debug read loads raw word, clears bit
// - both command bits set: only debug write
// - flag cleared only by writing one
// - command register writable in special mode only
// - command bits cleared by hardware only
`timescale 1ns/1ps
module sep_ecc_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire sep_pkg::sep_sys_req_t i_sys_req,
  output sep_pkg::sep_sys_rsp_t o_sys_rsp,
  output sep_pkg::sep_mem_req_t o_mem_req,
  input wire logic [2*sep_pkg::WORD_W-1:0] i_mem_rdata,
  input wire logic i_special_mode,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq,
  output logic o_double_err,
  output logic o_ready
);
  import sep_pkg::*;

  function automatic logic [CHK_W-1:0] ecc_gen(input logic [DATA_W-1:0] d);
    logic [CHK_W-1:0] c;
    c = '0;
    for (int j = 0; j < CHK_W; j++) begin
      c[j] = ~(^(d & ECC_MASKS[j]));
    end
    return c;
  endfunction

  // syndrome equal to one column flips that bit; any other nonzero syndrome is double
  function automatic sep_dec_t ecc_fix(input logic [WORD_W-1:0] w);
    sep_dec_t r;
    logic [CHK_W-1:0] syn;
    logic [CHK_W-1:0] col;
    r.word = w;
    r.single = 1'b0;
    r.dbl = 1'b0;
    syn = w[WORD_W-1:DATA_W] ^ ecc_gen(w[DATA_W-1:0]);
    if (syn != '0) begin
      r.dbl = 1'b1;
      for (int i = 0; i < DATA_W; i++) begin
        for (int j = 0; j < CHK_W; j++) begin
          col[j] = ECC_MASKS[j][i];
        end
        if (syn == col) begin
          r.word[i] = ~w[i];
          r.single = 1'b1;
          r.dbl = 1'b0;
        end
      end
      for (int j = 0; j < CHK_W; j++) begin
        if (syn == (6'h01 << j)) begin
          r.word[DATA_W+j] = ~w[DATA_W+j];
          r.single = 1'b1;
          r.dbl = 1'b0;
        end
      end
    end
    return r;
  endfunction

  function automatic logic [WORD_W-1:0] protect(input logic [DATA_W-1:0] d);
    return {ecc_gen(d), d};
  endfunction

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  sep_state_t state_q, state_d;
  sep_mem_req_t mem_q, mem_d;
  sep_sys_rsp_t rsp_q, rsp_d;
  logic [MEM_AW-1:0] cnt_q, cnt_d;
  logic rdy_q, rdy_d;
  logic dbl_q, dbl_d;
  logic irq_q;
  logic irq_en_q, flag_q, rrd_q, dw_q, dr_q;
  logic [PTR_W-1:0] ptr_q;
  logic [DATA_W-1:0] debug_raw_word_q;
  logic [CHK_W-1:0] dchk_q;
  logic [31:0] avs_rdata_q;
  logic avs_wait_q;
  logic sbe_set, dw_clr, dr_clr, dbg_load;

  // decode of the location currently addressed
  sep_dec_t dec_lo, dec_hi;
  assign dec_lo = ecc_fix(i_mem_rdata[WORD_W-1:0]);
  assign dec_hi = ecc_fix(i_mem_rdata[2*WORD_W-1:WORD_W]);

  wire logic [31:0] fixed_data = {dec_hi.word[DATA_W-1:0], dec_lo.word[DATA_W-1:0]};
  wire logic [1:0] sgl = {dec_hi.single, dec_lo.single};
  wire logic [1:0] dbl = {dec_hi.dbl, dec_lo.dbl};
  wire logic [1:0] touched = {|i_sys_req.be[3:2], |i_sys_req.be[1:0]};
  wire logic aligned = (i_sys_req.be == 4'hf) || (i_sys_req.be == 4'h3) || (i_sys_req.be == 4'hc);
  wire logic [31:0] merged = be_merge(fixed_data, i_sys_req.wdata, i_sys_req.be);
  // only halves with a lone error are written back; a double half stays as stored
  wire logic [1:0] repair_we = sgl & ~dbl & {2{~rrd_q}};
  // a double error in any touched half drops the whole merge write
  wire logic rmw_block = |(dbl & touched);
  // pointer bit 0 picks the half word of the location
  wire logic [1:0] dbg_we = ptr_q[0] ? 2'b10 : 2'b01;
  wire logic [DATA_W-1:0] dbg_raw_data = ptr_q[0] ? i_mem_rdata[WORD_W+DATA_W-1:WORD_W] : i_mem_rdata[DATA_W-1:0];
  wire logic [CHK_W-1:0] dbg_raw_chk = ptr_q[0] ? i_mem_rdata[2*WORD_W-1:WORD_W+DATA_W] :
                                       i_mem_rdata[WORD_W-1:DATA_W];

  always_comb begin
    state_d = state_q;
    mem_d = '0;
    mem_d.addr = mem_q.addr;
    rsp_d = '0;
    rsp_d.rdata = rsp_q.rdata;
    cnt_d = cnt_q;
    rdy_d = rdy_q;
    dbl_d = 1'b0;
    sbe_set = 1'b0;
    dw_clr = 1'b0;
    dr_clr = 1'b0;
    dbg_load = 1'b0;
    case (state_q)
      ST_INIT: begin
        mem_d.addr = cnt_q;
        mem_d.we = 2'b11;
        mem_d.wdata = {ZERO_CHECK, 16'h0000, ZERO_CHECK, 16'h0000};
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == MEM_AW'(MEM_DEPTH - 1)) begin
          state_d = ST_IDLE;
          rdy_d = 1'b1;
        end
      end
      ST_IDLE: begin
        // system requests first, debug only when the bus is quiet
        if (i_sys_req.valid && !rsp_q.done) begin
          mem_d.addr = i_sys_req.addr;
          if (i_sys_req.write && aligned) begin
            mem_d.we = touched;
            mem_d.wdata = {protect(i_sys_req.wdata[31:16]), protect(i_sys_req.wdata[15:0])};
            rsp_d.done = 1'b1;
          end else if (i_sys_req.write) begin
            state_d = ST_RMW;
          end else begin
            state_d = ST_READ;
          end
        end else if (dw_q) begin
          mem_d.addr = ptr_q[PTR_W-1:1];
          mem_d.we = dbg_we;
          mem_d.wdata = {dchk_q, debug_raw_word_q, dchk_q, debug_raw_word_q};
          dw_clr = 1'b1;
        end else if (dr_q) begin
          mem_d.addr = ptr_q[PTR_W-1:1];
          state_d = ST_DBG_RD;
        end
      end
      ST_READ: begin
        rsp_d.done = 1'b1;
        rsp_d.rdata = fixed_data;
        rsp_d.err = |dbl;
        dbl_d = |dbl;
        sbe_set = |sgl;
        mem_d.we = repair_we;
        mem_d.wdata = {dec_hi.word, dec_lo.word};
        state_d = (|repair_we) ? ST_REPAIR : ST_IDLE;
      end
      ST_RMW: begin
        rsp_d.done = 1'b1;
        if (rmw_block) begin
          rsp_d.err = 1'b1;
          dbl_d = 1'b1;
        end else begin
          mem_d.we = touched;
          mem_d.wdata = {protect(merged[31:16]), protect(merged[15:0])};
          sbe_set = |sgl;
        end
        state_d = ST_IDLE;
      end
      ST_REPAIR: begin
        // one extra cycle, so a back-to-back request waits while the repair lands
        if (!rsp_q.done) begin
          state_d = ST_IDLE;
        end
      end
      ST_DBG_RD: begin
        dbg_load = 1'b1;
        dr_clr = 1'b1;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= ST_INIT;
      mem_q <= '0;
      rsp_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
      dbl_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mem_q <= mem_d;
      rsp_q <= rsp_d;
      cnt_q <= cnt_d;
      rdy_q <= rdy_d;
      dbl_q <= dbl_d;
    end
  end

  // avalon slave: one wait cycle, then accept
  wire logic wr_acc = i_avs_write && !avs_wait_q;
  wire logic [31:0] wd = i_avs_writedata;
  wire logic [3:0] be = i_avs_byteenable;
  // register select, shared by the read and write decode
  wire logic sel_ctrl = (i_avs_address == OFS_CTRL);
  wire logic sel_status = (i_avs_address == OFS_STATUS);
  wire logic sel_ptr = (i_avs_address == OFS_PTR);
  wire logic sel_debug_raw_word = (i_avs_address == OFS_DEBUG_RAW_WORD);
  wire logic sel_dchk = (i_avs_address == OFS_DCHK);
  wire logic sel_cmd = (i_avs_address == OFS_DCMD);
  wire logic wr_ctrl = wr_acc && sel_ctrl;
  wire logic wr_status = wr_acc && sel_status;
  wire logic wr_ptr = wr_acc && sel_ptr;
  wire logic wr_debug_raw_word = wr_acc && sel_debug_raw_word;
  wire logic wr_dchk = wr_acc && sel_dchk;
  wire logic wr_cmd = wr_acc && sel_cmd && i_special_mode && be[0];
  wire logic dbg_busy = dw_q || dr_q;
  wire logic dw_set = wr_cmd && !dbg_busy && wd[BIT_DW];
  wire logic dr_set = wr_cmd && !dbg_busy && wd[BIT_DR] && !wd[BIT_DW];
  wire logic flag_clr = wr_status && be[0] && wd[BIT_FLAG];
  wire logic [31:0] ptr_new = be_merge({20'h0, ptr_q, 1'b0}, wd, be);
  wire logic [31:0] debug_raw_word_new = be_merge({16'h0, debug_raw_word_q}, wd, be);

  // unmapped offsets read as zero
  wire logic [31:0] rd_val =
    sel_ctrl ? {31'h0, irq_en_q} :
    sel_status ? {30'h0, rdy_q, flag_q} :
    sel_ptr ? {20'h0, ptr_q, 1'b0} :
    sel_debug_raw_word ? {16'h0, debug_raw_word_q} :
    sel_dchk ? {26'h0, dchk_q} :
    sel_cmd ? {24'h0, rrd_q, 5'h00, dw_q, dr_q} : 32'h0;

  // read data captured in the wait cycle, standing when wait drops
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      avs_wait_q <= 1'b1;
      avs_rdata_q <= '0;
    end else begin
      avs_wait_q <= !((i_avs_read || i_avs_write) && avs_wait_q);
      if (i_avs_read && avs_wait_q) begin
        avs_rdata_q <= rd_val;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_en_q <= RST_IRQ_EN;
      flag_q <= 1'b0;
      rrd_q <= RST_RRD;
      dw_q <= 1'b0;
      dr_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      if (wr_ctrl && be[0]) begin
        irq_en_q <= wd[BIT_IRQ_EN];
      end
      if (wr_cmd) begin
        rrd_q <= wd[BIT_RRD];
      end
      // a hardware set beats a same-cycle software clear
      flag_q <= sbe_set || (flag_q && !flag_clr);
      dw_q <= dw_set || (dw_q && !dw_clr);
      dr_q <= dr_set || (dr_q && !dr_clr);
      irq_q <= flag_q && irq_en_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ptr_q <= RST_PTR;
      debug_raw_word_q <= RST_DEBUG_RAW_WORD;
      dchk_q <= RST_DCHK;
    end else begin
      if (wr_ptr) begin
        ptr_q <= ptr_new[PTR_W:1];
      end
      // a debug read load beats a software write to the debug registers
      if (dbg_load) begin
        debug_raw_word_q <= dbg_raw_data;
        dchk_q <= dbg_raw_chk;
      end else begin
        if (wr_debug_raw_word) begin
          debug_raw_word_q <= debug_raw_word_new[DATA_W-1:0];
        end
        if (wr_dchk && be[0]) begin
          dchk_q <= wd[CHK_W-1:0];
        end
      end
    end
  end

  assign o_sys_rsp = rsp_q;
  assign o_mem_req = mem_q;
  assign o_avs_readdata = avs_rdata_q;
  assign o_avs_waitrequest = avs_wait_q;
  assign o_irq = irq_q;
  assign o_double_err = dbl_q;
  assign o_ready = rdy_q;

endmodule

// ---- tb/sep_mem_model.sv ----
`timescale 1ns/1ps
module sep_mem_model (
  input wire logic i_clk,
  input wire sep_pkg::sep_mem_req_t i_req,
  output logic [2*sep_pkg::WORD_W-1:0] o_rdata
);
  import sep_pkg::*;
  logic [2*WORD_W-1:0] mem_q [MEM_DEPTH];
  // asynchronous read from the registered address
  assign o_rdata = mem_q[i_req.addr];
  always_ff @(posedge i_clk) begin
    if (i_req.we[0]) begin
      mem_q[i_req.addr][WORD_W-1:0] <= i_req.wdata[WORD_W-1:0];
    end
    if (i_req.we[1]) begin
      mem_q[i_req.addr][2*WORD_W-1:WORD_W] <= i_req.wdata[2*WORD_W-1:WORD_W];
    end
  end
endmodule

// ---- tb/sep_ecc_top_properties.sv ----
`timescale 1ns/1ps
module sep_ecc_top_properties (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire sep_pkg::sep_sys_req_t i_sys_req,
  input wire sep_pkg::sep_sys_rsp_t o_sys_rsp,
  input wire sep_pkg::sep_mem_req_t o_mem_req,
  input wire logic o_irq,
  input wire logic o_double_err,
  input wire logic o_ready
);
  import sep_pkg::*;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  logic aligned;
  assign aligned = i_sys_req.write && (i_sys_req.be inside {4'hf, 4'h3, 4'hc});
  function automatic logic [5:0] ecc(input logic [15:0] d);
    ecc = ~{^(d & 16'h993c), ^(d & 16'h3e8a), ^(d & 16'hee60), ^(d & 16'he1d1), ^(d & 16'h13c7), ^(d & 16'h443f)};
  endfunction
  sequence s_take;
    $rose(i_sys_req.valid) && o_ready;
  endsequence
  sequence s_no_write;
    o_mem_req.we == 2'b00 ##1 o_mem_req.we == 2'b00;
  endsequence
  a_fill_fence: assert property (!o_ready |-> !o_sys_rsp.done) else $error("access done during fill");
  a_ready_hold: assert property (o_ready |=> o_ready) else $error("ready dropped");
  a_fill_zero: assert property (!o_ready && o_mem_req.we != 2'b00 |->
    o_mem_req.wdata == {6'h3f, 16'h0, 6'h3f, 16'h0}) else $error("fill word wrong");
  a_aligned_once: assert property (s_take and aligned |-> ##1 o_sys_rsp.done &&
    o_mem_req.we == {i_sys_req.be[2], i_sys_req.be[0]}) else $error("aligned write timing");
  a_aligned_code: assert property (o_sys_rsp.done && aligned && i_sys_req.be[0] |->
    o_mem_req.wdata[21:0] == {ecc(i_sys_req.wdata[15:0]), i_sys_req.wdata[15:0]}) else $error("check bits wrong");
  a_two_cycle: assert property (s_take and !aligned |-> ##2 o_sys_rsp.done) else $error("read or merge timing");
  a_err_keeps: assert property (o_sys_rsp.done && o_sys_rsp.err |-> s_no_write) else $error("write on error");
  a_err_out: assert property (o_sys_rsp.done && o_sys_rsp.err |-> ##[0:1] o_double_err) else $error("no dbl");
  a_dbl_quiet: assert property (o_double_err && !o_irq |=> !o_irq [*2]) else $error("irq on dbl");
  a_repair_gap: assert property (o_sys_rsp.done && !i_sys_req.write && o_mem_req.we != 2'b00 |=>
    !(o_sys_rsp.done && !i_sys_req.write) [*3]) else $error("read too soon after repair");
endmodule
bind sep_ecc_top sep_ecc_top_properties i_sep_ecc_top_properties (.i_clk(i_clk), .i_rst(i_rst),
  .i_sys_req(i_sys_req), .o_sys_rsp(o_sys_rsp), .o_mem_req(o_mem_req), .o_irq(o_irq),
  .o_double_err(o_double_err), .o_ready(o_ready));

// ---- tb/sep_ecc_top_test.sv ----
`timescale 1ns/1ps
module sep_ecc_top_test;
  import sep_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic smode = 1'b1;
  sep_sys_req_t req = '0;
  sep_sys_rsp_t rsp;
  sep_mem_req_t mreq;
  logic [2*WORD_W-1:0] mrd;
  logic [4:0] aa = 5'h00;
  logic ard = 1'b0;
  logic awr = 1'b0;
  logic [31:0] awd = 32'h0;
  logic [31:0] aq, q, srd;
  logic wt, irq, derr, rdy, serr;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  int gap;
  always #2.5 i_clk = ~i_clk;
  sep_ecc_top i_sep_ecc_top (.i_clk(i_clk), .i_rst(i_rst), .i_sys_req(req), .o_sys_rsp(rsp), .o_mem_req(mreq),
    .i_mem_rdata(mrd), .i_special_mode(smode), .i_avs_address(aa), .i_avs_read(ard), .i_avs_write(awr),
    .i_avs_writedata(awd), .i_avs_byteenable(4'hf), .o_avs_readdata(aq), .o_avs_waitrequest(wt), .o_irq(irq),
    .o_double_err(derr), .o_ready(rdy));
  sep_mem_model i_sep_mem_model (.i_clk(i_clk), .i_req(mreq), .o_rdata(mrd));
  function automatic logic [5:0] ecc(input logic [15:0] d);
    ecc = ~{^(d & 16'h993c), ^(d & 16'h3e8a), ^(d & 16'hee60), ^(d & 16'he1d1), ^(d & 16'h13c7), ^(d & 16'h443f)};
  endfunction
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic avs(input logic w, input logic [4:0] a, input logic [31:0] d);
    aa <= a;
    awd <= d;
    awr <= w;
    ard <= !w;
    do begin
      @(posedge i_clk);
    end while (wt !== 1'b0);
    q = aq;
    awr <= 1'b0;
    ard <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rdchk(input logic [4:0] a, input string nm, input logic [31:0] e);
    avs(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  // issue a debug command, then poll until both command bits clear
  task automatic dbg(input logic [31:0] cmd);
    avs(1'b1, OFS_DCMD, cmd);
    do begin
      avs(1'b0, OFS_DCMD, 32'h0);
    end while (q[1:0] !== 2'b00);
  endtask
  // a read followed at once by another: edges from the first done to the second done
  task automatic rd_pair(output int g);
    req <= '{1'b1, 1'b0, 10'h005, 4'hf, 32'h0};
    do begin
      @(posedge i_clk);
    end while (rsp.done !== 1'b1);
    req.wdata <= 32'h1;
    g = 0;
    do begin
      @(posedge i_clk);
      g++;
    end while (rsp.done !== 1'b1);
    srd = rsp.rdata;
    req.valid <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic sys(input logic w, input logic [3:0] be, input logic [31:0] d);
    req <= '{1'b1, w, 10'h005, be, d};
    do begin
      @(posedge i_clk);
    end while (rsp.done !== 1'b1);
    srd = rsp.rdata;
    serr = rsp.err;
    req.valid <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic sysrd(input logic [31:0] e, input logic ee);
    sys(1'b0, 4'hf, 32'h0);
    chk("rdata", e, srd);
    chk("err", {31'h0, ee}, {31'h0, serr});
  endtask
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    avs(1'b1, OFS_DEBUG_RAW_WORD, 32'h5a5a);
    avs(1'b1, OFS_DCMD, 32'h1);
    rdchk(OFS_STATUS, "status fill", 32'h0);
    rdchk(OFS_DCMD, "cmd held", 32'h1);
    chk("ready low", 32'h0, {31'h0, rdy});
    while (rdy !== 1'b1) @(posedge i_clk);
    rdchk(OFS_STATUS, "status", 32'h2);
    dbg(32'h0);
    rdchk(OFS_DEBUG_RAW_WORD, "fill data", 32'h0);
    rdchk(OFS_DCHK, "fill check", 32'h3f);
    $display("test fill done");
    sys(1'b1, 4'hf, 32'h1234abcd);
    sysrd(32'h1234abcd, 1'b0);
    avs(1'b1, OFS_PTR, 32'h16);
    dbg(32'h1);
    rdchk(OFS_DEBUG_RAW_WORD, "high data", 32'h1234);
    rdchk(OFS_DCHK, "high check", {26'h0, ecc(16'h1234)});
    sys(1'b1, 4'h4, 32'h00ef0000);
    sys(1'b1, 4'he, 32'h99887700);
    sysrd(32'h998877cd, 1'b0);
    $display("test write done");
    avs(1'b1, OFS_CTRL, 32'h1);
    avs(1'b1, OFS_PTR, 32'h14);
    avs(1'b1, OFS_DEBUG_RAW_WORD, 32'h77cc);
    avs(1'b1, OFS_DCHK, {26'h0, ecc(16'h77cd)});
    dbg(32'h2);
    sysrd(32'h998877cd, 1'b0);
    rdchk(OFS_STATUS, "flag", 32'h3);
    chk("irq", 32'h1, {31'h0, irq});
    dbg(32'h1);
    rdchk(OFS_DEBUG_RAW_WORD, "repaired", 32'h77cd);
    avs(1'b1, OFS_STATUS, 32'h0);
    rdchk(OFS_STATUS, "flag kept", 32'h3);
    avs(1'b1, OFS_STATUS, 32'h1);
    rdchk(OFS_STATUS, "flag clear", 32'h2);
    chk("irq low", 32'h0, {31'h0, irq});
    avs(1'b1, OFS_DEBUG_RAW_WORD, 32'h77cc);
    dbg(32'h2);
    rd_pair(gap);
    chk("repair gap", 32'h4, gap);
    chk("pair data", 32'h998877cd, srd);
    rd_pair(gap);
    chk("clean gap", 32'h3, gap);
    avs(1'b1, OFS_STATUS, 32'h1);
    $display("test repair done");
    avs(1'b1, OFS_CTRL, 32'h0);
    avs(1'b1, OFS_DEBUG_RAW_WORD, 32'h77cc);
    dbg(32'h82);
    sysrd(32'h998877cd, 1'b0);
    rdchk(OFS_STATUS, "flag again", 32'h3);
    chk("irq masked", 32'h0, {31'h0, irq});
    dbg(32'h81);
    rdchk(OFS_DEBUG_RAW_WORD, "not repaired", 32'h77cc);
    avs(1'b1, OFS_STATUS, 32'h1);
    $display("test no repair done");
    avs(1'b1, OFS_DEBUG_RAW_WORD, 32'h77ce);
    dbg(32'h83);
    rdchk(OFS_DCMD, "cmd idle", 32'h80);
    sysrd(32'h998877ce, 1'b1);
    rdchk(OFS_STATUS, "no flag", 32'h2);
    sys(1'b1, 4'h1, 32'h000000ff);
    chk("merge err", 32'h1, {31'h0, serr});
    dbg(32'h81);
    rdchk(OFS_DEBUG_RAW_WORD, "unchanged", 32'h77ce);
    $display("test double done");
    smode <= 1'b0;
    avs(1'b1, OFS_DCMD, 32'h1);
    rdchk(OFS_DCMD, "locked", 32'h80);
    $display("test mode done");
    stop_test();
  end
endmodule
